/* File: include/ccc_consts.svh */
`ifndef CCC_CONSTS_SVH
`define CCC_CONSTS_SVH
`define CCC_CMD_CODE 8'h47
`define CCC_LEN_IV 8'h1e
`define CCC_LEN_PWR 8'h26
`define CCC_ANSWER 8'h52
`define CCC_SLOT_BASE 8'h02
`define CCC_WORDS_PER_BLOCK 8'h43
`define CCC_SEND_BYTES 9'h192
`define CCC_PKG_BYTES 13'h1000
`define CCC_MAX_CH 2
`endif

/* File: include/ccc_pkg.sv */
package ccc_pkg;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } ccc_byte_t;
   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } ccc_sample_t;
   typedef enum logic [2:0] {
      CCC_IDLE = 3'b000,
      CCC_LEN = 3'b001,
      CCC_BODY = 3'b010,
      CCC_RUN = 3'b011,
      CCC_DRAIN = 3'b100
   } ccc_state_t;
endpackage

/* File: hw/ccc_capture.sv */
`timescale 1ns/1ps
`include "ccc_consts.svh"
module ccc_capture #(
   parameter int BUF_WORDS = 134
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input ccc_pkg::ccc_byte_t i_rx,
   input ccc_pkg::ccc_sample_t i_sample,
   input wire logic i_tx_ready,
   output ccc_pkg::ccc_byte_t o_tx,
   output logic o_capture_en,
   output logic [6:0] o_select,
   output logic o_power_layout,
   output logic o_busy,
   output logic o_reject
);
   import ccc_pkg::*;
   initial
   begin
      if (BUF_WORDS != 2 * 67)
      begin
         $error("BUF_WORDS must equal two channels of 67 words");
      end
   end

   // Capture memory: two halves of BUF_WORDS each, ping-ponged.
   logic [23:0] mem [0:2*BUF_WORDS-1];
   ccc_state_t state, next_state;
   logic [7:0] len, next_len;
   logic [7:0] idx, next_idx;
   logic [6:0] sel, next_sel;
   logic bad, next_bad;
   logic [15:0] m_cnt, next_m_cnt;
   logic [16:0] blocks, next_blocks;
   logic [7:0] wr_ptr, next_wr_ptr;
   logic wr_half, next_wr_half;
   logic send_pend, next_send_pend;
   logic [8:0] tx_cnt, next_tx_cnt;
   logic [7:0] rd_ptr, next_rd_ptr;
   logic [1:0] byte_sel, next_byte_sel;
   logic [12:0] pkg_cnt, next_pkg_cnt;
   logic [23:0] tx_word;
   ccc_byte_t tx, next_tx;
   logic rej, next_rej;
   logic [5:0] slot;
   logic slot_on;
   logic [1:0] pos;
   logic [3:0] nsel;
   logic [16:0] blk_step;
   logic [8:0] wr_addr;
   logic [8:0] rd_addr;

   assign slot = 6'((idx - `CCC_SLOT_BASE) >> 2);
   // Only seven slots are kept; a later power slot reads as deselected.
   assign slot_on = (slot < 6'h07) ? sel[3'(slot)] : 1'b0;
   assign pos = 2'(idx - `CCC_SLOT_BASE);
   assign nsel = 4'(sel[0]) + 4'(sel[1]) + 4'(sel[2]) + 4'(sel[3])
      + 4'(sel[4]) + 4'(sel[5]) + 4'(sel[6]);
   // A half holds two blocks of one channel, or one block each of two channels.
   assign blk_step = (nsel == 4'h1) ? 17'h00002 : 17'h00001;
   // The halves sit one after the other; the filled half is read while the other fills.
   assign wr_addr = wr_half ? 9'(BUF_WORDS) + 9'(wr_ptr) : 9'(wr_ptr);
   assign rd_addr = wr_half ? 9'(rd_ptr) : 9'(BUF_WORDS) + 9'(rd_ptr);
   assign tx_word = mem[rd_addr];

   // Command parser, capture counters and answer streamer.
   always_comb
   begin
      next_state = state;
      next_len = len;
      next_idx = idx;
      next_sel = sel;
      next_bad = bad;
      next_m_cnt = m_cnt;
      next_blocks = blocks;
      next_wr_ptr = wr_ptr;
      next_wr_half = wr_half;
      next_send_pend = send_pend;
      next_tx_cnt = tx_cnt;
      next_rd_ptr = rd_ptr;
      next_byte_sel = byte_sel;
      next_pkg_cnt = pkg_cnt;
      next_tx = tx;
      next_rej = 1'b0;
      if (tx.valid && i_tx_ready)
      begin
         next_tx.valid = 1'b0;
      end
      case (state)
         CCC_IDLE:
         begin
            if (i_rx.valid && i_rx.data == `CCC_CMD_CODE)
            begin
               next_state = CCC_LEN;
            end
         end
         CCC_LEN:
         begin
            if (i_rx.valid)
            begin
               next_len = i_rx.data;
               next_idx = `CCC_SLOT_BASE;
               next_sel = 7'h00;
               next_bad = !(i_rx.data == `CCC_LEN_IV || i_rx.data == `CCC_LEN_PWR);
               next_state = CCC_BODY;
            end
         end
         CCC_BODY:
         begin
            if (i_rx.valid)
            begin
               next_idx = idx + 8'h01;
               // Body bytes run from index 2 to len + 1; the last two carry M.
               if (idx == len + 8'h01)
               begin
                  // Final byte: low half of M, high half already kept.
                  next_m_cnt = {m_cnt[7:0], i_rx.data};
                  if (bad || nsel == 4'h0 || nsel > `CCC_MAX_CH)
                  begin
                     next_rej = 1'b1;
                     next_state = CCC_IDLE;
                  end
                  else
                  begin
                     // (2*M+1) blocks of 67 words per channel for two channels; one channel fills whole halves, so it gets 2*M+2.
                     next_blocks = {m_cnt[7:0], i_rx.data, 1'b0} + 17'h00001;
                     next_wr_ptr = 8'h00;
                     next_wr_half = 1'b0;
                     next_send_pend = 1'b0;
                     next_pkg_cnt = 13'h0000;
                     next_state = CCC_RUN;
                  end
               end
               else if (idx == len)
               begin
                  next_m_cnt = {8'h00, i_rx.data};
               end
               else if (pos == 2'h0)
               begin
                  next_bad = bad | (i_rx.data != 8'h00);
               end
               else
               begin
                  // Slot bytes must be all one or all zero.
                  if (i_rx.data == 8'h01)
                  begin
                     if (pos == 2'h1 && slot < 6'h07)
                     begin
                        next_sel[3'(slot)] = 1'b1;
                     end
                     else
                     begin
                        // A stray one, or a later power slot selected, is refused.
                        next_bad = bad | !slot_on;
                     end
                  end
                  else
                  begin
                     next_bad = bad | (i_rx.data != 8'h00) | (pos != 2'h1 && slot_on);
                  end
               end
            end
         end
         CCC_RUN, CCC_DRAIN:
         begin
            if (state == CCC_RUN && i_sample.valid)
            begin
               if (wr_ptr == 8'(BUF_WORDS - 1))
               begin
                  next_wr_ptr = 8'h00;
                  next_wr_half = ~wr_half;
                  next_send_pend = 1'b1;
                  next_tx_cnt = 9'h000;
                  next_rd_ptr = 8'h00;
                  next_byte_sel = 2'h0;
                  if (blocks <= blk_step)
                  begin
                     next_state = CCC_DRAIN;
                  end
                  next_blocks = blocks - blk_step;
               end
               else
               begin
                  next_wr_ptr = wr_ptr + 8'h01;
               end
            end
            if (send_pend && (!tx.valid || i_tx_ready))
            begin
               next_tx.valid = 1'b1;
               next_pkg_cnt = (pkg_cnt == `CCC_PKG_BYTES - 13'h0001) ? 13'h0000 : pkg_cnt + 13'h0001;
               if (tx_cnt == 9'h000)
               begin
                  next_tx.data = `CCC_ANSWER;
               end
               else
               begin
                  // Top byte of the 32-bit sample was dropped on write.
                  case (byte_sel)
                     2'h0: next_tx.data = tx_word[23:16];
                     2'h1: next_tx.data = tx_word[15:8];
                     default: next_tx.data = tx_word[7:0];
                  endcase
                  next_byte_sel = (byte_sel == 2'h2) ? 2'h0 : byte_sel + 2'h1;
                  if (byte_sel == 2'h2)
                  begin
                     next_rd_ptr = rd_ptr + 8'h01;
                  end
               end
               next_tx_cnt = tx_cnt + 9'h001;
               if (tx_cnt == `CCC_SEND_BYTES)
               begin
                  next_send_pend = 1'b0;
               end
            end
            // Go idle only once the host has taken the last answer byte.
            if (state == CCC_DRAIN && !next_send_pend && !next_tx.valid)
            begin
               next_state = CCC_IDLE;
            end
         end
         default:
         begin
            next_state = CCC_IDLE;
         end
      endcase
   end

   // Sample memory write; no reset, contents are data only.
   always_ff @(posedge i_core_clk)
   begin
      if (state == CCC_RUN && i_sample.valid)
      begin
         mem[wr_addr] <= i_sample.data[23:0];
      end
   end

   // State registers.
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state <= CCC_IDLE;
         len <= 8'h00;
         idx <= 8'h00;
         sel <= 7'h00;
         bad <= 1'b0;
         m_cnt <= 16'h0000;
         blocks <= 17'h00000;
         wr_ptr <= 8'h00;
         wr_half <= 1'b0;
         send_pend <= 1'b0;
         tx_cnt <= 9'h000;
         rd_ptr <= 8'h00;
         byte_sel <= 2'h0;
         pkg_cnt <= 13'h0000;
         tx <= '0;
         rej <= 1'b0;
         o_capture_en <= 1'b0;
         o_select <= 7'h00;
         o_power_layout <= 1'b0;
         o_busy <= 1'b0;
      end
      else
      begin
         state <= next_state;
         len <= next_len;
         idx <= next_idx;
         sel <= next_sel;
         bad <= next_bad;
         m_cnt <= next_m_cnt;
         blocks <= next_blocks;
         wr_ptr <= next_wr_ptr;
         wr_half <= next_wr_half;
         send_pend <= next_send_pend;
         tx_cnt <= next_tx_cnt;
         rd_ptr <= next_rd_ptr;
         byte_sel <= next_byte_sel;
         pkg_cnt <= next_pkg_cnt;
         tx <= next_tx;
         rej <= next_rej;
         o_capture_en <= (next_state == CCC_RUN);
         o_select <= next_sel;
         o_power_layout <= (next_len == `CCC_LEN_PWR);
         o_busy <= (next_state != CCC_IDLE);
      end
   end

   assign o_tx = tx;
   assign o_reject = rej;
endmodule

/* File: testbench/ccc_capture_sva.sv */
`timescale 1ns/1ps
module ccc_capture_sva (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_tx_ready,
   input ccc_pkg::ccc_byte_t o_tx,
   input wire logic o_capture_en,
   input wire logic [6:0] o_select,
   input wire logic o_busy,
   input wire logic o_reject
);
   import ccc_pkg::*;
   // One clock domain, so clocking and reset are given once.
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   property p_rej; o_reject |-> !o_capture_en; endproperty
   a_rej: assert property (p_rej) else $error("capture on reject");
   property p_rej2; o_reject |=> !o_capture_en ##1 !o_capture_en; endproperty
   a_rej2: assert property (p_rej2) else $error("capture after reject");
   property p_pulse; o_reject |=> !o_reject; endproperty
   a_pulse: assert property (p_pulse) else $error("reject too long");
   property p_hold; o_tx.valid && !i_tx_ready |=> $stable(o_tx); endproperty
   a_hold: assert property (p_hold) else $error("tx byte dropped");
   property p_max; o_capture_en |-> $countones(o_select) inside {[1:2]}; endproperty
   a_max: assert property (p_max) else $error("bad select count");
   property p_busy; o_capture_en |-> o_busy; endproperty
   a_busy: assert property (p_busy) else $error("capture not busy");
   property p_idle; !o_busy |-> !o_tx.valid; endproperty
   a_idle: assert property (p_idle) else $error("tx while idle");
   property p_sel; o_capture_en && $past(o_capture_en) |-> $stable(o_select); endproperty
   a_sel: assert property (p_sel) else $error("select moved");
   c_cap: cover property ($rose(o_capture_en));
   c_rej: cover property (o_reject);
   c_tx: cover property (o_tx.valid && i_tx_ready);
endmodule

/* File: testbench/ccc_host.sv */
`timescale 1ns/1ps
module ccc_host (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input ccc_pkg::ccc_byte_t i_tx,
   output logic o_ready = 1'b0,
   output ccc_pkg::ccc_byte_t o_got
);
   import ccc_pkg::*;
   logic [3:0] lfsr = 4'h9;
   // Ready stalls in a pseudo-random pattern, as a busy link would.
   always @(negedge i_core_clk)
   begin
      lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
      o_ready <= lfsr[0] | lfsr[1];
   end
   // A byte is taken only on the edge where ready meets valid.
   always @(posedge i_core_clk or negedge i_reset_n)
      if (!i_reset_n)
         o_got <= '0;
      else
         o_got <= '{valid: i_tx.valid && o_ready, data: i_tx.data};
endmodule

/* File: testbench/continuous_capture_command_tb.sv */
`timescale 1ns/1ps
module continuous_capture_command_tb;
   import ccc_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_reset_n = 1'b0;
   ccc_byte_t i_rx = '0;
   ccc_sample_t i_sample = '0;
   logic i_tx_ready;
   ccc_byte_t o_tx;
   ccc_byte_t got;
   logic o_capture_en;
   logic o_power_layout;
   logic o_busy;
   logic o_reject;
   logic [6:0] o_select;
   int n_errors = 0;
   int n_checks = 0;
   int n_rej = 0;
   int k;
   logic [31:0] seed = 32'h9;
   logic [7:0] exp_q[$];
   always #10 i_core_clk = ~i_core_clk;
   ccc_capture ccc_capture_i (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
      .i_rx(i_rx), .i_sample(i_sample), .i_tx_ready(i_tx_ready), .o_tx(o_tx),
      .o_capture_en(o_capture_en), .o_select(o_select),
      .o_power_layout(o_power_layout), .o_busy(o_busy), .o_reject(o_reject));
   ccc_host ccc_host_i (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
      .i_tx(o_tx), .o_ready(i_tx_ready), .o_got(got));
   // Reject is a one-cycle pulse, so it is counted where it happens.
   always @(posedge i_core_clk)
      if (o_reject === 1'b1)
         n_rej <= n_rej + 1;
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(logic [7:0] g, logic [7:0] e);
      n_checks++;
      if (g !== e)
         $display("Error %0t: got %h want %h", $time, g, e);
      if (g !== e)
         n_errors++;
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic put(logic [7:0] b);
      @(negedge i_core_clk);
      i_rx <= '{valid: 1'b1, data: b};
   endtask
   // Bytes go back to back; the count is zero, the tail bytes being zero.
   task automatic req(logic [7:0] n, logic [6:0] sel, logic [7:0] z);
      put(8'h47);
      put(n);
      for (int i = 0; i < n; i++)
         put(i >= 28 ? 8'h00 : i % 4 == 0 ? z : {7'h00, sel[i/4]});
      @(negedge i_core_clk);
      i_rx <= '0;
   endtask
   // One capture with M of zero: one half of samples, then the 403-byte answer.
   task automatic run_cap(logic [7:0] n, logic [6:0] sel);
      req(n, sel, 8'h00);
      k = 0;
      while (o_capture_en !== 1'b1 && k < 4)
      begin
         @(negedge i_core_clk);
         k++;
      end
      chk({7'h00, o_capture_en}, 8'h01);
      chk({1'b0, o_select}, {1'b0, sel});
      chk({7'h00, o_power_layout}, {7'h00, n == 8'h26});
      exp_q = {8'h52};
      fork
         begin
            for (int s = 0; s < 134; s++)
            begin
               seed = xs(seed);
               i_sample <= '{valid: 1'b1, data: seed};
               exp_q.push_back(seed[23:16]);
               exp_q.push_back(seed[15:8]);
               exp_q.push_back(seed[7:0]);
               @(negedge i_core_clk);
            end
            i_sample <= '0;
         end
         begin
            k = 0;
            while (exp_q.size() > 0 && k < 5000)
            begin
               @(negedge i_core_clk);
               k++;
               if (got.valid === 1'b1)
                  chk(got.data, exp_q.pop_front());
            end
         end
      join
      if (k >= 5000)
      begin
         $display("Error %0t: answer stream timed out", $time);
         n_errors++;
      end
      repeat (20) @(negedge i_core_clk);
      chk({7'h00, o_capture_en}, 8'h00);
      chk({7'h00, o_busy}, 8'h00);
      $display("capture test done, length %0d", n);
   endtask
   initial
   begin
      repeat (2) @(negedge i_core_clk);
      i_reset_n <= 1'b1;
      put(8'h4a);
      run_cap(8'h1e, 7'h22);
      // Power layout: apparent power A and active power A.
      run_cap(8'h26, 7'h09);
      // Wrong length, three slots, no slot, nonzero top byte.
      for (int c = 0; c < 4; c++)
      begin
         k = n_rej;
         req(c == 0 ? 8'h1f : 8'h1e, c == 1 ? 7'h07 : c == 2 ? 7'h00 : 7'h01,
            c == 3 ? 8'h01 : 8'h00);
         repeat (4) @(negedge i_core_clk);
         chk({7'h00, o_capture_en}, 8'h00);
         chk(8'(n_rej - k), 8'h01);
      end
      $display("reject test done");
      summarize();
   end
endmodule
bind ccc_capture ccc_capture_sva ccc_capture_sva_i (.i_core_clk(i_core_clk),
   .i_reset_n(i_reset_n), .i_tx_ready(i_tx_ready), .o_tx(o_tx),
   .o_capture_en(o_capture_en), .o_select(o_select), .o_busy(o_busy),
   .o_reject(o_reject));
